// *** src/dlhb_top.sv ***
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dlhb_map.svh"

// How it works
// - Host write of select bit chooses which ping-pong buffer gets sent.
// - Reading the select bit reports the next free transmit buffer, or the one not on air when both are pending.
// - A buffer still pending makes the select bit read the other buffer.
// - Bit-oriented: send code the counted number of times, then end event, halt.
// - Bit-oriented with zero count repeats the code word without end.
// - Message-oriented: count is length in octets, header in, check octets out.
// - Receive pointer bit names the buffer holding the newest message.
// - Bit-oriented receive raises end event after the counted repetitions.
// - Bit-oriented receive with zero count never raises the end event.
// - Message-oriented receive loads count with stored size, check octets included.
// - Mode bit picks bit-oriented (0) or message-oriented (1) for both directions.
module dlhb_top
  import dlhb_pkg::*;
#(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = 16
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Transmit stream to the framer.
  output logic [7:0]       tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  // Receive stream from the deframer.
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_end_i,
  // End-of-transfer events.
  output logic             tx_end_of_transfer_irq_o,
  output logic             rx_end_of_transfer_irq_o
);
  dlhb_top_s   r_reg;
  dlhb_top_s   r_next;
  logic [7:0]  txm [2][128];
  logic        req;
  logic        wr;
  logic [2:0]  rgn;
  logic        wr_tx;
  logic        wr_rx;
  logic        wr_ctrl;
  logic        rd_tx;
  logic        stop_req;
  logic        wsel;
  logic        wmode;
  logic        avail;
  logic [6:0]  cnt_a;
  logic [6:0]  cnt_m1;
  logic        zero_len;
  logic        push;
  logic        fifo_ready;
  logic [7:0]  push_byte;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_rd_data;
  logic [6:0]  bidx;

  // A request is taken once; ack follows one cycle later and then drops.
  assign req     = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign rgn     = wb_adr_i[`DLHB_RGN_MSB:`DLHB_RGN_LSB];
  assign bidx    = wb_adr_i[`DLHB_IDX_MSB:`DLHB_IDX_LSB];
  assign wr_tx   = wr && wb_adr_i == `DLHB_ADR_TX;
  assign wr_rx   = wr && wb_adr_i == `DLHB_ADR_RX;
  assign wr_ctrl = wr && wb_adr_i == `DLHB_ADR_CTRL;
  assign rd_tx   = req && !wb_we_i && wb_adr_i == `DLHB_ADR_TX;
  assign wsel    = wb_dat_i[`DLHB_SEL_BIT];
  assign wmode   = wb_dat_i[`DLHB_MODE_BIT];
  assign stop_req = wr_ctrl && wb_dat_i[`DLHB_STOP_BIT];

  // With both buffers pending, the one not on air is reported.
  assign avail = (r_reg.busy == 2'b00) ? r_reg.prio :
                 (r_reg.busy == 2'b11) ? !r_reg.act : r_reg.busy[0];

  assign cnt_a     = r_reg.cnt[r_reg.act];
  assign cnt_m1    = cnt_a - 7'h01;
  assign zero_len  = (r_reg.mode == `DLHB_MODE_MOS) && cnt_a == 7'h00;
  // Bit-oriented mode repeats the code word held in the first slot.
  assign push_byte = txm[r_reg.act][(r_reg.mode == `DLHB_MODE_MOS) ? r_reg.idx : 7'h00];
  assign push      = (r_reg.st == TX_SEND) && !zero_len && !stop_req && fifo_ready;

  assign wb_dat_o                 = r_reg.dat;
  assign wb_ack_o                 = r_reg.ack;
  assign tx_end_of_transfer_irq_o = r_reg.eot;

  always_comb begin
    r_next     = r_reg;
    r_next.ack = req;
    r_next.eot = 1'b0;

    unique case (r_reg.st)
      TX_IDLE: begin
        if (r_reg.busy[r_reg.prio] || r_reg.busy[!r_reg.prio]) begin
          r_next.act  = r_reg.busy[r_reg.prio] ? r_reg.prio : !r_reg.prio;
          r_next.idx  = '0;
          r_next.reps = '0;
          r_next.st   = TX_SEND;
        end
      end
      TX_SEND: begin
        if (stop_req || zero_len ||
            (push && r_reg.mode == `DLHB_MODE_MOS && r_reg.idx == cnt_m1) ||
            (push && r_reg.mode == `DLHB_MODE_BOS && cnt_a != 7'h00 && r_reg.reps == cnt_m1)) begin
          r_next.busy[r_reg.act] = 1'b0;
          r_next.prio            = !r_reg.act;
          r_next.eot             = !stop_req;
          r_next.st              = TX_IDLE;
        end else if (push && r_reg.mode == `DLHB_MODE_MOS) begin
          r_next.idx = r_reg.idx + 7'h01;
        end else if (push && cnt_a != 7'h00) begin
          r_next.reps = r_reg.reps + 7'h01;
        end
        // A zero count in bit-oriented mode falls through and repeats for good.
      end
    endcase

    if (wr_tx) begin
      r_next.last_sel = wsel;
      // Selecting a buffer still pending would corrupt it, so it is refused.
      if (!r_reg.busy[wsel]) begin
        r_next.busy[wsel] = 1'b1;
        r_next.cnt[wsel]  = wb_dat_i[`DLHB_CNT_MSB:0];
        if (r_reg.busy == 2'b00) begin
          r_next.prio = wsel;
        end
      end
    end
    if (wr_ctrl) begin
      r_next.mode = wmode;
    end

    if (req) begin
      r_next.dat = '0;
      if (!wb_we_i) begin
        if (wb_adr_i == `DLHB_ADR_TX) begin
          r_next.dat[7:0] = {avail, r_reg.cnt[r_reg.last_sel]};
        end else if (wb_adr_i == `DLHB_ADR_RX) begin
          r_next.dat[7:0] = rx_reg;
        end else if (wb_adr_i == `DLHB_ADR_CTRL) begin
          r_next.dat[`DLHB_MODE_BIT] = r_reg.mode;
        end else if (wb_adr_i == `DLHB_ADR_STAT) begin
          r_next.dat[3:0] = {r_reg.act, r_reg.st == TX_SEND, r_reg.busy};
        end else if (rgn == `DLHB_RGN_TXB0 || rgn == `DLHB_RGN_TXB1) begin
          r_next.dat[7:0] = txm[wb_adr_i[`DLHB_BUF_BIT]][bidx];
        end else if (rgn == `DLHB_RGN_RXB0 || rgn == `DLHB_RGN_RXB1) begin
          r_next.dat[7:0] = rx_rd_data;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg      <= '0;
      r_reg.cnt  <= '0;
      r_reg.mode <= `DLHB_MODE_BOS;
      r_reg.st   <= TX_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Host fills the message buffers; a buffer on air should not be rewritten.
  always_ff @(posedge clk_i) begin
    if (wr && (rgn == `DLHB_RGN_TXB0 || rgn == `DLHB_RGN_TXB1)) begin
      txm[wb_adr_i[`DLHB_BUF_BIT]][bidx] <= wb_dat_i[7:0];
    end
  end

  // The FIFO absorbs framer stalls; when it fills, the fetch engine waits.
  dlhb_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_byte),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  (tx_data_o)
  );

  dlhb_rx_ctrl u_rx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .mode_i     (r_reg.mode),
    .wr_i       (wr_rx),
    .wdata_i    (wb_dat_i[7:0]),
    .reg_o      (rx_reg),
    .rd_buf_i   (wb_adr_i[`DLHB_BUF_BIT]),
    .rd_idx_i   (bidx),
    .rd_data_o  (rx_rd_data),
    .rx_valid_i (rx_valid_i),
    .rx_data_i  (rx_data_i),
    .rx_end_i   (rx_end_i),
    .eot_o      (rx_end_of_transfer_irq_o)
  );

  default clocking top_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wb_ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  tx_claim_a: assert property (wr_tx && !r_reg.busy[wsel] |=> r_reg.busy[$past(wsel)])
    else $error("selected transmit buffer was not queued");
  next_free_a: assert property (rd_tx && r_reg.busy == 2'b00 |=> wb_dat_o[7] == $past(r_reg.prio))
    else $error("select bit does not report the free buffer");
  busy_other_a: assert property (rd_tx && r_reg.busy == 2'b01 |=> wb_ack_o && wb_dat_o[7])
    else $error("select bit reports a pending buffer");
  bos_halt_a: assert property (push && r_reg.mode == `DLHB_MODE_BOS && cnt_a != 7'h00
    && r_reg.reps == cnt_m1 |=> tx_end_of_transfer_irq_o && r_reg.st == TX_IDLE)
    else $error("bit-oriented send did not stop after its count");
  bos_forever_a: assert property (r_reg.st == TX_SEND && r_reg.mode == `DLHB_MODE_BOS && cnt_a == 7'h00
    && !stop_req && !wr_ctrl |=> r_reg.st == TX_SEND && !tx_end_of_transfer_irq_o)
    else $error("endless bit-oriented send ended");
  mos_len_a: assert property (push && r_reg.mode == `DLHB_MODE_MOS && r_reg.idx == cnt_m1
    |=> tx_end_of_transfer_irq_o ##1 !tx_end_of_transfer_irq_o)
    else $error("message send did not end at its length");
  buf_free_a: assert property (tx_end_of_transfer_irq_o |-> !r_reg.busy[r_reg.act])
    else $error("transmit buffer still busy after its end event");
  mode_wr_a: assert property (wr_ctrl |=> r_reg.mode == $past(wmode))
    else $error("mode bit did not follow the host write");

  // Hand-off: the select bit must never steer the host at the buffer that is on air.
  both_busy_a: assert property (rd_tx && r_reg.busy == 2'b11
    |=> wb_dat_o[`DLHB_SEL_BIT] == !$past(r_reg.act))
    else $error("select bit reports the buffer on air");
  one_busy_a: assert property (rd_tx && r_reg.busy == 2'b10
    |=> wb_ack_o && !wb_dat_o[`DLHB_SEL_BIT])
    else $error("select bit reports pending buffer one");
  refuse_busy_a: assert property (wr_tx && r_reg.busy[wsel]
    |=> r_reg.cnt[$past(wsel)] == $past(r_reg.cnt[wsel]))
    else $error("write to a pending buffer changed its count");
  on_air_busy_a: assert property (r_reg.st == TX_SEND
    |-> r_reg.busy[r_reg.act])
    else $error("buffer on air is not marked busy");
  pick_prio_a: assert property (r_reg.st == TX_IDLE && r_reg.busy[r_reg.prio]
    |=> r_reg.st == TX_SEND && r_reg.act == $past(r_reg.prio))
    else $error("engine did not start on the queued buffer");
  start_send_a: assert property (r_reg.st == TX_IDLE && r_reg.busy != 2'b00
    |=> r_reg.st == TX_SEND)
    else $error("queued buffer left waiting");
  prio_after_a: assert property (tx_end_of_transfer_irq_o
    |-> r_reg.prio == !r_reg.act)
    else $error("finished buffer still offered first");

  // Counting: every fetch of a counted run advances by one byte or one repetition, and a run ends once.
  mos_step_a: assert property (push && r_reg.mode == `DLHB_MODE_MOS && r_reg.idx != cnt_m1
    |=> r_reg.idx == $past(r_reg.idx) + 7'h01)
    else $error("message fetch skipped or repeated a byte");
  bos_step_a: assert property (push && r_reg.mode == `DLHB_MODE_BOS && cnt_a != 7'h00
    && r_reg.reps != cnt_m1 |=> r_reg.reps == $past(r_reg.reps) + 7'h01)
    else $error("repetition count did not advance");
  zero_len_a: assert property (r_reg.st == TX_SEND && zero_len && !stop_req
    |=> tx_end_of_transfer_irq_o && r_reg.st == TX_IDLE)
    else $error("empty message did not end at once");
  tx_irq_pulse_a: assert property (tx_end_of_transfer_irq_o
    |=> !tx_end_of_transfer_irq_o)
    else $error("transmit end event longer than one cycle");
  stop_quiet_a: assert property (stop_req && r_reg.st == TX_SEND
    |=> r_reg.st == TX_IDLE && !tx_end_of_transfer_irq_o)
    else $error("stopped send raised an end event or kept running");
  eot_only_send_a: assert property (tx_end_of_transfer_irq_o |-> $past(r_reg.st) == TX_SEND)
    else $error("transmit end event without a running send");

  // Bus and stream side: answers only to a taken request, data held while the framer stalls.
  ack_only_req_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without a taken request");
  dat_hi_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data has bits above the low byte");
  rx_read_a: assert property (req && !wb_we_i && wb_adr_i == `DLHB_ADR_RX
    |=> wb_dat_o[7:0] == $past(rx_reg))
    else $error("receive register read does not match its state");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit byte changed before the framer took it");
  mode_hold_a: assert property (!wr_ctrl |=> r_reg.mode == $past(r_reg.mode))
    else $error("mode bit changed without a host write");

  mos_done_c: cover property (push && r_reg.mode == `DLHB_MODE_MOS ##[1:300] tx_end_of_transfer_irq_o);
  bos_done_c: cover property (r_reg.mode == `DLHB_MODE_BOS && tx_end_of_transfer_irq_o);
  fifo_full_c: cover property (r_reg.st == TX_SEND && !fifo_ready);
  // A stop of a running send and two queued buffers are the rarer paths worth seeing.
  stop_c: cover property (stop_req && r_reg.st == TX_SEND);
  both_busy_c: cover property (r_reg.busy == 2'b11);

endmodule

// *** src/dlhb_map.svh ***
`ifndef DLHB_MAP_SVH
`define DLHB_MAP_SVH

// Register word offsets, as byte addresses on the bus.
`define DLHB_ADR_TX    12'h000
`define DLHB_ADR_RX    12'h004
`define DLHB_ADR_CTRL  12'h008
`define DLHB_ADR_STAT  12'h00c

// Buffer windows, decoded from address bits 11:9; one byte per word.
`define DLHB_RGN_MSB   11
`define DLHB_RGN_LSB   9
`define DLHB_RGN_TXB0  3'h2
`define DLHB_RGN_TXB1  3'h3
`define DLHB_RGN_RXB0  3'h4
`define DLHB_RGN_RXB1  3'h5
`define DLHB_BUF_BIT   9
`define DLHB_IDX_MSB   8
`define DLHB_IDX_LSB   2

// Field positions and reset values.
`define DLHB_SEL_BIT   7
`define DLHB_CNT_MSB   6
`define DLHB_MODE_BIT  0
`define DLHB_STOP_BIT  1
`define DLHB_TX_RST    8'h00
`define DLHB_RX_RST    8'h00
`define DLHB_MODE_BOS  1'b0
`define DLHB_MODE_MOS  1'b1

`endif

// *** src/dlhb_pkg.sv ***
package dlhb_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } dlhb_txst_e;

  typedef struct packed {
    logic             ack;
    logic [31:0]      dat;
    logic             mode;
    logic [1:0]       busy;
    logic [1:0][6:0]  cnt;
    logic             prio;
    logic             last_sel;
    logic             act;
    logic [6:0]       idx;
    logic [6:0]       reps;
    dlhb_txst_e       st;
    logic             eot;
  } dlhb_top_s;

  typedef struct packed {
    logic       ptr;
    logic [6:0] cnt;
    logic [6:0] widx;
    logic [6:0] reps;
    logic       done;
    logic       eot;
  } dlhb_rx_s;

endpackage

// *** src/dlhb_fifo.sv ***
`timescale 1ns/1ps

module dlhb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Filling side.
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side.
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } dlhb_fifo_s;

  dlhb_fifo_s     r_reg;
  dlhb_fifo_s     r_next;
  logic [W-1:0]   mem [D];
  logic           full;
  logic           empty;

  // The extra pointer bit tells a full ring from an empty one.
  assign empty       = (r_reg.wp == r_reg.rp);
  assign full        = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[r_reg.rp[AW-1:0]];

  always_comb begin
    r_next = r_reg;
    if (in_valid_i && !full) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[r_reg.wp[AW-1:0]] <= in_data_i;
    end
  end

endmodule

// *** src/dlhb_rx_ctrl.sv ***
`timescale 1ns/1ps
`include "dlhb_map.svh"

module dlhb_rx_ctrl
  import dlhb_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Mode and register access.
  input  wire logic       mode_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      reg_o,
  // Buffer read port for the host.
  input  wire logic       rd_buf_i,
  input  wire logic [6:0] rd_idx_i,
  output logic [7:0]      rd_data_o,
  // Receive stream from the deframer.
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_end_i,
  // Events.
  output logic            eot_o
);
  dlhb_rx_s   r_reg;
  dlhb_rx_s   r_next;
  logic [7:0] mem [2][128];
  logic [6:0] cnt_m1;
  logic       mos_end;

  assign cnt_m1    = r_reg.cnt - 7'h01;
  assign mos_end   = (mode_i == `DLHB_MODE_MOS) && rx_valid_i && rx_end_i;
  assign reg_o     = {r_reg.ptr, r_reg.cnt};
  assign rd_data_o = mem[rd_buf_i][rd_idx_i];
  assign eot_o     = r_reg.eot;

  always_comb begin
    r_next     = r_reg;
    r_next.eot = 1'b0;
    if (wr_i) begin
      r_next.ptr  = wdata_i[`DLHB_SEL_BIT];
      r_next.cnt  = wdata_i[`DLHB_CNT_MSB:0];
      r_next.reps = '0;
      r_next.done = 1'b0;
    end
    if (mode_i == `DLHB_MODE_MOS) begin
      // Messages longer than the buffer keep overwriting the last slot.
      if (rx_valid_i && r_reg.widx != 7'h7f) begin
        r_next.widx = r_reg.widx + 7'h01;
      end
      if (mos_end) begin
        r_next.ptr  = !r_reg.ptr;
        r_next.cnt  = (r_reg.widx == 7'h7f) ? 7'h7f : r_reg.widx + 7'h01;
        r_next.widx = '0;
      end
    end else if (rx_valid_i && r_reg.cnt != 7'h00 && !r_reg.done) begin
      // Each delivered code word is one whole repetition of the message.
      if (r_reg.reps == cnt_m1) begin
        r_next.eot  = 1'b1;
        r_next.done = 1'b1;
        r_next.reps = '0;
      end else begin
        r_next.reps = r_reg.reps + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg     <= '0;
      {r_reg.ptr, r_reg.cnt} <= `DLHB_RX_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mode_i == `DLHB_MODE_MOS && rx_valid_i) begin
      mem[!r_reg.ptr][r_reg.widx] <= rx_data_i;
    end
  end

  default clocking rx_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ptr_flip_a: assert property (mos_end |=> r_reg.ptr != $past(r_reg.ptr))
    else $error("newest buffer pointer did not move at message end");
  bos_eot_a: assert property (!mode_i && rx_valid_i && !wr_i && r_reg.cnt != 7'h00 && !r_reg.done
    && r_reg.reps == cnt_m1 |=> eot_o && r_reg.done)
    else $error("receive end of transfer missing after last repetition");
  bos_inf_a: assert property (eot_o |-> $past(r_reg.cnt) != 7'h00 && $past(mode_i) == `DLHB_MODE_BOS)
    else $error("receive end of transfer with zero count");
  mos_size_a: assert property (mos_end && $past(r_reg.widx) != 7'h7f && r_reg.widx != 7'h7f
    |=> r_reg.cnt == $past(r_reg.widx) + 7'h01)
    else $error("receive count does not match stored bytes");

endmodule

// *** verification/dlhb_link_model.sv ***
`timescale 1ns/1ps
// Far side of the link: a framer taking transmit bytes and a deframer delivering received ones.
module dlhb_link_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pace set by the bench.
  input  wire logic       stall_i,
  input  wire logic       slow_i,
  // Transmit stream.
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // Receive stream.
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_end_o
);
  logic [7:0] got_q[$];

  initial begin
    tx_ready_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o   = 1'b0;
  end

  // A slow framer takes a byte only every other cycle, so the fifo backs up.
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o && !rst_i) got_q.push_back(tx_data_i);
    tx_ready_o <= !rst_i && !stall_i && (!slow_i || !tx_ready_o);
  end

  // Idle data lines show the last byte inverted so a stale byte is never mistaken for a good one.
  task automatic send(input logic [31:0] m, input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= m[8*i+:8];
      rx_end_o   <= last && (i == n - 1);
      @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_end_o   <= 1'b0;
    rx_data_o  <= ~rx_data_o;
  endtask
endmodule

// *** verification/dlhb_top_test.sv ***
`timescale 1ns/1ps
`include "dlhb_map.svh"

module dlhb_top_test;
  import dlhb_pkg::*;

  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_end;
  logic        tx_irq;
  logic        rx_irq;
  logic        stall;
  logic        slow;
  int          bad_count;
  int          cmp_count;
  int          tx_ev;
  int          rx_ev;

  dlhb_top #(.FIFO_W(8), .FIFO_D(16)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_end_i(rx_end), .tx_end_of_transfer_irq_o(tx_irq), .rx_end_of_transfer_irq_o(rx_irq));

  dlhb_link_model link (
    .clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_end_o(rx_end));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (tx_irq === 1'b1) tx_ev <= tx_ev + 1;
    if (rx_irq === 1'b1) rx_ev <= rx_ev + 1;
  end

  task automatic results();
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request stands until ack is seen at a rising edge; a silent slave is cut off.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    sel  <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    q = wb_dat_o;
    if (n >= 100) chk("ack", 1, 0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask

  // Waits for a transmit end event count, then for the fifo to run dry.
  task automatic wait_tx(input int target);
    int n;
    n = 0;
    while ((tx_ev < target || tx_valid !== 1'b0) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk("tx_events", target, tx_ev);
  endtask

  task automatic chk_q(input int len, input logic [31:0] bytes, input logic rep);
    chk("tx_len", len, link.got_q.size());
    for (int i = 0; i < len && i < link.got_q.size(); i++) chk("tx_byte", rep ? bytes[7:0] : bytes[8*i+:8], link.got_q[i]);
    link.got_q.delete();
  endtask

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0; wdat = 32'h0;
    stall = 1'b0; slow = 1'b1; bad_count = 0; cmp_count = 0; tx_ev = 0; rx_ev = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`DLHB_ADR_TX, 8'h00, "tx_reg");
    rdc(`DLHB_ADR_RX, 8'h00, "rx_reg");
    rdc(`DLHB_ADR_CTRL, 8'h00, "mode");
    wr(12'h010, 8'hff);
    rdc(12'h010, 8'h00, "unmapped");
    wr(`DLHB_ADR_CTRL, 8'h01);
    for (int i = 0; i < 3; i++) wr(12'h400 + 12'(4 * i), 8'(8'h11 * (i + 1)));
    wr(`DLHB_ADR_TX, 8'h03);
    rdc(`DLHB_ADR_TX, 8'h83, "sel_busy0");
    wait_tx(1);
    chk_q(3, 32'h00332211, 1'b0);
    rdc(`DLHB_ADR_TX, 8'h83, "sel_free");
    // A second start of the same busy buffer must neither queue nor repeat it.
    for (int i = 0; i < 4; i++) wr(12'h600 + 12'(4 * i), 8'(8'h44 + 8'h11 * i));
    wr(`DLHB_ADR_TX, 8'h84);
    wr(`DLHB_ADR_TX, 8'h84);
    rdc(`DLHB_ADR_TX, 8'h04, "sel_after1");
    wait_tx(2);
    repeat (20) @(posedge clk_i);
    chk("tx_events", 2, tx_ev);
    chk_q(4, 32'h77665544, 1'b0);
    wr(`DLHB_ADR_CTRL, 8'h00);
    wr(12'h400, 8'h5a);
    wr(`DLHB_ADR_TX, 8'h04);
    wait_tx(3);
    chk_q(4, 32'h5a, 1'b1);
    // Endless repeat with the framer stalled fills the fifo, then it drains freely.
    stall <= 1'b1;
    wr(`DLHB_ADR_TX, 8'h80);
    repeat (40) @(posedge clk_i);
    chk("fifo_full_valid", 1, tx_valid);
    chk("stalled_len", 0, link.got_q.size());
    // Buffer 0 queued behind the endless run: the select bit must name the one not on air.
    wr(`DLHB_ADR_TX, 8'h02);
    rdc(`DLHB_ADR_TX, 8'h02, "sel_both");
    rdc(`DLHB_ADR_STAT, 8'h0f, "status");
    stall <= 1'b0;
    slow  <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk("forever_run", 1, link.got_q.size() > 40);
    chk("tx_events", 3, tx_ev);
    wr(`DLHB_ADR_CTRL, 8'h02);
    wait_tx(4);
    link.got_q.delete();
    wr(`DLHB_ADR_CTRL, 8'h01);
    link.send(32'h00332211, 3, 1'b1);
    @(posedge clk_i);
    rdc(`DLHB_ADR_RX, 8'h83, "rx_mos1");
    for (int i = 0; i < 3; i++) rdc(12'ha00 + 12'(4 * i), 8'(8'h11 * (i + 1)), "rx_buf1");
    link.send(32'h0000bbaa, 2, 1'b1);
    @(posedge clk_i);
    rdc(`DLHB_ADR_RX, 8'h02, "rx_mos2");
    rdc(12'h804, 8'hbb, "rx_buf0");
    wr(`DLHB_ADR_CTRL, 8'h00);
    wr(`DLHB_ADR_RX, 8'h03);
    link.send(32'h07070707, 2, 1'b0);
    repeat (3) @(posedge clk_i);
    chk("rx_events", 0, rx_ev);
    link.send(32'h07, 1, 1'b0);
    repeat (3) @(posedge clk_i);
    chk("rx_events", 1, rx_ev);
    link.send(32'h07070707, 4, 1'b0);
    wr(`DLHB_ADR_RX, 8'h00);
    link.send(32'h07070707, 4, 1'b0);
    repeat (3) @(posedge clk_i);
    chk("rx_events", 1, rx_ev);
    results();
  end

  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule
